// [common/tcs_pkg.sv]
/*
 * Shared constants and types for the time converter SPI command block.
 * Assumes a 250 MHz core clock; SPI pins are sampled as synchronous inputs.
 */
package tcs_pkg;
    // opcode coding
    localparam logic [7:0] OPC_POWER      = 8'h30;
    localparam logic [7:0] OPC_INIT       = 8'h18;
    localparam logic [2:0] OPC_WRITE_CFG  = 3'h4;
    localparam logic [2:0] OPC_READ_RES   = 3'h3;
    localparam logic [2:0] OPC_READ_CFG   = 3'h2;

    // register space
    localparam int         CFG_COUNT      = 18;
    localparam logic [4:0] CFG_LAST       = 5'h11;
    localparam logic [4:0] RES_FIRST      = 5'h08;
    localparam logic [7:0] CFG_RESET_VAL  = 8'h00;
    localparam logic [4:0] DIV_REG_LO     = 5'h03;
    localparam logic [4:0] DIV_REG_MID    = 5'h04;
    localparam logic [4:0] DIV_REG_HI     = 5'h05;

    // result coding
    localparam int          CHANNELS      = 4;
    localparam int          RES_BYTES     = 24;
    localparam int          BYTES_PER_CH  = 6;
    localparam int          FIELD_BITS    = 24;
    localparam int          FINE_BITS     = 20;
    localparam int          PHASE_BITS    = 16;
    localparam logic [23:0] EMPTY_MARK    = 24'hffffff;
    localparam logic [3:0]  FINE_PAD      = 4'h0;

    // timing
    localparam logic [4:0] REF_OPEN_CNT      = 5'h10;
    localparam int         CLK_PERIOD_NS     = 4;
    localparam int         SELECT_HOLD_NS    = 100;
    localparam int         SELECT_HOLD_CYCLES =
        (SELECT_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_CMD   = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ  = 2'b11,
        ST_SKIP  = 2'b10
    } tcs_frame_t;
endpackage

// [design/tcs_result_coder.sv]
/*
 * Codes one channel's stop result for SPI readout.
 * Assumes the phase input is the stop position as a fraction of the
 * reference period, scaled to 2^16.
 */
`timescale 1ns/1ps
module tcs_result_coder
    import tcs_pkg::*;
(
    input  wire logic                  empty_in,
    input  wire logic [FIELD_BITS-1:0] index_in,
    input  wire logic [PHASE_BITS-1:0] phase_in,
    input  wire logic [FINE_BITS-1:0]  div_in,
    output logic      [FIELD_BITS-1:0] index_field_out,
    output logic      [FIELD_BITS-1:0] fine_field_out
);
    // phase < 2^16, so the scaled count never reaches div_in
    wire [FINE_BITS+PHASE_BITS-1:0] scaled = phase_in * div_in;  // see [RULE_20]
    wire [FINE_BITS-1:0] fine_lsb = scaled[FINE_BITS+PHASE_BITS-1:PHASE_BITS];  // see [RULE_21]

    // output width settings are deliberately not inputs here, see [RULE_19]
    assign index_field_out = empty_in ? EMPTY_MARK : index_in;  // see [RULE_18]
    assign fine_field_out  = empty_in ? EMPTY_MARK : {FINE_PAD, fine_lsb};  // see [RULE_23]
endmodule

// [design/tcs_spi_cmd.sv]
/*
 * SPI command interpreter of a four channel time converter: power reset,
 * init, config write/read with auto increment, result readout.
 * Assumes all pins synchronous to core_clk_in and SCK far slower than it.
 */
// Notes on behaviour
// [RULE_01] power opcode resets chip, halts measurement
// [RULE_02] init opcode initialises and starts measuring
// [RULE_03] 100 plus address writes config 0..17
// [RULE_04] 011 plus address reads results 8..31
// [RULE_05] 010 plus address reads config 0..17
// [RULE_06] reset held for select hold time
// [RULE_07] after power reset: stopped, config defaults
// [RULE_08] init keeps configuration contents
// [RULE_09] stops open after 16 reference pulses
// [RULE_10] host waits power-on delay after init
// [RULE_11] init restart keeps stored FIFO results
// [RULE_12] only configuration registers are writable
// [RULE_13] write opcode then data byte stored
// [RULE_14] further write bytes go to next address
// [RULE_15] read shifts addressed register out on MISO
// [RULE_16] read continues with following registers
// [RULE_17] host suppresses LVDS readout during SPI reads
// [RULE_18] empty channel reads all ones marker
// [RULE_19] LVDS width settings ignored for SPI
// [RULE_20] stop result counts period subdivisions
// [RULE_21] largest stop result is count minus one
// [RULE_22] host fits subdivision count to LVDS width
// [RULE_23] stop result 20 bits, top four zero
// [RULE_24] host opens each access with select pulse
// [RULE_25] sample falling, drive rising, MSB first
// [RULE_26] MISO released while select high
// [RULE_27] interrupt low while results are available
`timescale 1ns/1ps
module tcs_spi_cmd
    import tcs_pkg::*;
(
    input  wire logic                           core_clk_in,
    input  wire logic                           arst_n_in,
    input  wire logic                           spi_sck_in,
    input  wire logic                           select_line_n_in,
    input  wire logic                           spi_mosi_in,
    input  wire logic                           ref_clk_in,
    input  wire logic [CHANNELS-1:0]            chan_empty_in,
    input  wire logic [CHANNELS*FIELD_BITS-1:0] chan_index_in,
    input  wire logic [CHANNELS*PHASE_BITS-1:0] chan_phase_in,
    output logic                                spi_miso_out,
    output logic                                spi_miso_oe_out,
    output logic                                chip_reset_out,
    output logic                                state_reset_out,
    output logic                                measuring_out,
    output logic                                stop_open_out,
    output logic                                irq_n_out,
    output logic      [CFG_COUNT*8-1:0]         cfg_flat_out
);
    tcs_frame_t frame_q;
    tcs_frame_t frame_d;
    logic [4:0] addr_q;
    logic       rd_res_q;
    logic [7:0] hold_cnt_q;
    logic [4:0] ref_cnt_q;
    logic       ref_q;
    logic       chip_reset_q;
    logic       state_reset_q;
    logic       measuring_q;
    logic       stop_open_q;
    logic       irq_n_q;
    logic [7:0] cfg_q [CFG_COUNT];
    logic [7:0] res_byte [RES_BYTES];
    logic [7:0] rx_byte;
    logic       rx_valid;
    logic [FINE_BITS-1:0] div_count;
    logic [FIELD_BITS-1:0] fine_ch0;

    // byte shifting on the SPI pins
    wire [7:0] rd_byte;
    tcs_spi_shifter u_shift (
        .core_clk_in  (core_clk_in),
        .arst_n_in    (arst_n_in),
        .sck_in       (spi_sck_in),
        .sel_n_in     (select_line_n_in),
        .mosi_in      (spi_mosi_in),
        .tx_byte_in   (rd_byte),
        .rx_byte_out  (rx_byte),
        .rx_valid_out (rx_valid),
        .miso_out     (spi_miso_out),
        .miso_oe_out  (spi_miso_oe_out)
    );

    // command decode on the first byte of a frame
    wire hold_busy  = (hold_cnt_q != 8'h00);
    wire cmd_byte   = rx_valid && (frame_q == ST_CMD) && !hold_busy;
    wire por_cmd    = cmd_byte && (rx_byte == OPC_POWER);  // see [RULE_01]
    wire init_cmd   = cmd_byte && (rx_byte == OPC_INIT);  // see [RULE_02]
    wire wr_op      = cmd_byte && (rx_byte[7:5] == OPC_WRITE_CFG);  // see [RULE_03]
    wire rdr_op     = cmd_byte && (rx_byte[7:5] == OPC_READ_RES);  // see [RULE_04]
    wire rdc_op     = cmd_byte && (rx_byte[7:5] == OPC_READ_CFG);  // see [RULE_05]
    wire addr_op    = wr_op || rdr_op || rdc_op;
    wire wr_byte    = rx_valid && (frame_q == ST_WRITE);
    wire wr_en      = wr_byte && (addr_q <= CFG_LAST);  // see [RULE_12]
    wire rd_step    = rx_valid && (frame_q == ST_READ);
    wire ref_rise   = ref_clk_in && !ref_q;
    wire ref_count  = ref_rise && measuring_q && (ref_cnt_q != REF_OPEN_CNT);

    // read data mux; addresses 8..17 exist in both spaces
    wire [4:0] res_off = addr_q - RES_FIRST;
    wire [7:0] res_sel = (addr_q >= RES_FIRST) ? res_byte[res_off] : 8'h00;
    wire [7:0] cfg_sel = (addr_q <= CFG_LAST) ? cfg_q[addr_q] : 8'h00;
    assign rd_byte = rd_res_q ? res_sel : cfg_sel;  // see [RULE_15]

    always_comb
    begin
        frame_d = frame_q;
        case (frame_q)
            ST_CMD:
                if (wr_op)
                    frame_d = ST_WRITE;
                else if (rdr_op || rdc_op)
                    frame_d = ST_READ;
                else if (rx_valid)
                    frame_d = ST_SKIP;
            ST_WRITE: frame_d = ST_WRITE;
            ST_READ:  frame_d = ST_READ;
            ST_SKIP:  frame_d = ST_SKIP;
            default:  frame_d = ST_CMD;
        endcase
        if (select_line_n_in)
            frame_d = ST_CMD;  // see [RULE_24]
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            frame_q  <= ST_CMD;
            addr_q   <= 5'h00;
            rd_res_q <= 1'b0;
        end
        else
        begin
            frame_q <= frame_d;
            if (addr_op)
            begin
                addr_q   <= rx_byte[4:0];  // see [RULE_13]
                rd_res_q <= rdr_op;
            end
            else if (wr_byte || rd_step)
                addr_q <= addr_q + 5'h01;  // see [RULE_14] see [RULE_16]
        end
    end

    // configuration bytes, one flop group per entry
    for (genvar i = 0; i < CFG_COUNT; i++)
    begin : g_cfg
        always_ff @(posedge core_clk_in or negedge arst_n_in)
        begin
            if (!arst_n_in)
                cfg_q[i] <= CFG_RESET_VAL;
            else if (por_cmd)
                cfg_q[i] <= CFG_RESET_VAL;  // see [RULE_07]
            else if (wr_en && addr_q == 5'(i))
                cfg_q[i] <= rx_byte;  // see [RULE_13]
        end
        assign cfg_flat_out[i*8 +: 8] = cfg_q[i];
    end

    // result coding per channel, laid out index then stop, MSB first
    assign div_count = {cfg_q[DIV_REG_HI][3:0], cfg_q[DIV_REG_MID], cfg_q[DIV_REG_LO]};
    for (genvar c = 0; c < CHANNELS; c++)
    begin : g_chan
        logic [FIELD_BITS-1:0] idx_f;
        logic [FIELD_BITS-1:0] fine_f;
        tcs_result_coder u_code (
            .empty_in        (chan_empty_in[c]),
            .index_in        (chan_index_in[c*FIELD_BITS +: FIELD_BITS]),
            .phase_in        (chan_phase_in[c*PHASE_BITS +: PHASE_BITS]),
            .div_in          (div_count),
            .index_field_out (idx_f),
            .fine_field_out  (fine_f)
        );
        assign res_byte[c*BYTES_PER_CH+0] = idx_f[23:16];
        assign res_byte[c*BYTES_PER_CH+1] = idx_f[15:8];
        assign res_byte[c*BYTES_PER_CH+2] = idx_f[7:0];
        assign res_byte[c*BYTES_PER_CH+3] = fine_f[23:16];
        assign res_byte[c*BYTES_PER_CH+4] = fine_f[15:8];
        assign res_byte[c*BYTES_PER_CH+5] = fine_f[7:0];
    end
    assign fine_ch0 = g_chan[0].fine_f;

    // power reset hold; new frames are skipped while it runs
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            hold_cnt_q   <= 8'h00;
            chip_reset_q <= 1'b0;
        end
        else
        begin
            if (por_cmd)
                hold_cnt_q <= 8'(SELECT_HOLD_CYCLES);  // see [RULE_06]
            else if (hold_busy)
                hold_cnt_q <= hold_cnt_q - 8'h01;
            chip_reset_q <= por_cmd || (hold_cnt_q > 8'h01);  // see [RULE_06]
        end
    end

    // measurement sequencing; init never touches channel FIFOs
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ref_q         <= 1'b0;
            ref_cnt_q     <= 5'h00;
            measuring_q   <= 1'b0;
            stop_open_q   <= 1'b0;
            state_reset_q <= 1'b0;
            irq_n_q       <= 1'b1;
        end
        else
        begin
            ref_q         <= ref_clk_in;
            state_reset_q <= init_cmd;  // see [RULE_08] see [RULE_11]
            irq_n_q       <= &chan_empty_in;  // see [RULE_27]
            if (por_cmd)
            begin
                measuring_q <= 1'b0;  // see [RULE_01]
                stop_open_q <= 1'b0;
                ref_cnt_q   <= 5'h00;
            end
            else if (init_cmd)
            begin
                measuring_q <= 1'b1;  // see [RULE_02]
                stop_open_q <= 1'b0;
                ref_cnt_q   <= 5'h00;
            end
            else
            begin
                if (ref_count)
                    ref_cnt_q <= ref_cnt_q + 5'h01;  // see [RULE_09]
                stop_open_q <= measuring_q && (ref_cnt_q == REF_OPEN_CNT);
            end
        end
    end

    assign chip_reset_out  = chip_reset_q;
    assign state_reset_out = state_reset_q;
    assign measuring_out   = measuring_q;
    assign stop_open_out   = stop_open_q;
    assign irq_n_out       = irq_n_q;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    power_halts_meas_a: assert property ( // see [RULE_01]
        por_cmd |=> !measuring_q && chip_reset_q && !stop_open_q)
        else $error("power opcode did not halt measurement");

    init_starts_meas_a: assert property ( // see [RULE_02]
        init_cmd |=> measuring_q && state_reset_q ##1 !state_reset_q)
        else $error("init opcode did not start measurement");

    reset_hold_a: assert property ( // see [RULE_06]
        por_cmd |=> chip_reset_q [*8])
        else $error("power reset released too early");

    cfg_default_a: assert property ( // see [RULE_07]
        por_cmd |=> cfg_flat_out == '0)
        else $error("config not at default after power reset");

    init_keeps_cfg_a: assert property ( // see [RULE_08]
        init_cmd |=> $stable(cfg_flat_out))
        else $error("init changed configuration");

    open_after_refs_a: assert property ( // see [RULE_09]
        $rose(stop_open_q) |-> $past(ref_cnt_q) == REF_OPEN_CNT && measuring_q)
        else $error("stops opened before 16 reference pulses");

    write_stores_a: assert property ( // see [RULE_13]
        wr_en && addr_q == 5'h02 |=> cfg_q[2] == $past(rx_byte))
        else $error("written byte not stored");

    write_increment_a: assert property ( // see [RULE_14]
        wr_byte |=> addr_q == 5'($past(addr_q) + 5'h01))
        else $error("write address did not advance");

    result_readonly_a: assert property ( // see [RULE_12]
        wr_byte && addr_q > CFG_LAST |=> $stable(cfg_flat_out))
        else $error("write outside config changed a register");

    empty_marker_a: assert property ( // see [RULE_18]
        chan_empty_in[0] |-> fine_ch0 == EMPTY_MARK && g_chan[0].idx_f == EMPTY_MARK)
        else $error("empty channel not marked");

    fine_range_a: assert property ( // see [RULE_21]
        !chan_empty_in[0] && div_count != '0 |-> fine_ch0[23:20] == FINE_PAD
            && fine_ch0[FINE_BITS-1:0] < div_count)
        else $error("stop result out of range");

    irq_follow_a: assert property ( // see [RULE_27]
        |(~chan_empty_in) |=> !irq_n_out)
        else $error("interrupt not asserted with results present");

    power_seen_c: cover property (por_cmd ##[1:200] !chip_reset_q);
    open_seen_c:  cover property (init_cmd ##[1:1000] stop_open_q);
    read_seen_c:  cover property (rd_step ##[1:1000] rd_step);
    write_seen_c: cover property (wr_en ##[1:1000] wr_en);
endmodule

// [design/tcs_spi_shifter.sv]
/*
 * SPI byte shifter: mode with clock idle low, input taken on falling SCK,
 * output changed on rising SCK, MSB first.
 * Assumes SCK is far slower than the core clock and synchronous to it.
 */
`timescale 1ns/1ps
module tcs_spi_shifter
    import tcs_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       arst_n_in,
    input  wire logic       sck_in,
    input  wire logic       sel_n_in,
    input  wire logic       mosi_in,
    input  wire logic [7:0] tx_byte_in,
    output logic      [7:0] rx_byte_out,
    output logic            rx_valid_out,
    output logic            miso_out,
    output logic            miso_oe_out
);
    logic       sck_q;
    logic [2:0] bit_cnt_q;
    logic [6:0] rx_sr_q;
    logic [6:0] tx_sr_q;

    wire sck_fall  = sck_q & ~sck_in;
    wire sck_rise  = ~sck_q & sck_in;
    wire take_bit  = sck_fall & ~sel_n_in;
    wire drive_bit = sck_rise & ~sel_n_in;
    wire byte_end  = take_bit & (bit_cnt_q == 3'h7);
    wire [7:0] rx_full = {rx_sr_q, mosi_in};

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            sck_q        <= 1'b0;
            bit_cnt_q    <= 3'h0;
            rx_sr_q      <= 7'h00;
            rx_byte_out  <= 8'h00;
            rx_valid_out <= 1'b0;
        end
        else
        begin
            sck_q        <= sck_in;
            rx_valid_out <= byte_end;
            if (sel_n_in)
                bit_cnt_q <= 3'h0;
            else if (take_bit)
                bit_cnt_q <= bit_cnt_q + 3'h1;
            if (take_bit)
                rx_sr_q <= rx_full[6:0];  // see [RULE_25]
            if (byte_end)
                rx_byte_out <= rx_full;
        end
    end

    // a new byte is fetched on the first rising edge of each byte slot
    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            miso_out    <= 1'b0;
            miso_oe_out <= 1'b0;
            tx_sr_q     <= 7'h00;
        end
        else
        begin
            miso_oe_out <= ~sel_n_in;  // see [RULE_26]
            if (drive_bit && bit_cnt_q == 3'h0)
            begin
                miso_out <= tx_byte_in[7];  // see [RULE_25]
                tx_sr_q  <= tx_byte_in[6:0];
            end
            else if (drive_bit)
            begin
                miso_out <= tx_sr_q[6];
                tx_sr_q  <= {tx_sr_q[5:0], 1'b0};
            end
        end
    end

    miso_release_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE_26]
        sel_n_in |=> !miso_oe_out)
        else $error("miso driven while select is high");

    byte_pulse_a: assert property (@(posedge core_clk_in) disable iff (!arst_n_in) // see [RULE_25]
        rx_valid_out |-> $past(sck_fall) && !$past(sel_n_in))
        else $error("byte completed without a falling sck");
endmodule

// [testbench/tcs_spi_cmd_tb_top.sv]
/*
 * Self-checking bench for the SPI command interpreter.
 * Assumes the SPI host model and the design package are compiled first.
 */
`timescale 1ns/1ps
module tcs_spi_cmd_tb_top
    import tcs_pkg::*;
;
    logic                           core_clk = 1'b0;
    logic                           arst_n;
    logic                           ref_clk;
    logic [CHANNELS-1:0]            chan_empty;
    logic [CHANNELS*FIELD_BITS-1:0] chan_index;
    logic [CHANNELS*PHASE_BITS-1:0] chan_phase;
    logic                           sck;
    logic                           sel_n;
    logic                           mosi;
    logic                           miso;
    logic                           miso_oe;
    logic                           miso_pin;
    logic                           chip_reset;
    logic                           measuring;
    logic                           stop_open;
    logic                           irq_n;
    logic                           state_reset;
    logic [CFG_COUNT*8-1:0]         cfg_flat;
    logic [7:0]                     rx_byte;
    logic                           rx_stb;
    logic [7:0]                     cfg_m [CFG_COUNT];
    logic [7:0]                     exp_q [$];
    int                             error_cnt = 0;
    int                             checked = 0;
    int                             init_pulses = 0;

    assign miso_pin = miso_oe ? miso : 1'bz;

    always #2 core_clk = ~core_clk;

    tcs_spi_cmd tcs_spi_cmd_i (
        .core_clk_in      (core_clk),
        .arst_n_in        (arst_n),
        .spi_sck_in       (sck),
        .select_line_n_in (sel_n),
        .spi_mosi_in      (mosi),
        .ref_clk_in       (ref_clk),
        .chan_empty_in    (chan_empty),
        .chan_index_in    (chan_index),
        .chan_phase_in    (chan_phase),
        .spi_miso_out     (miso),
        .spi_miso_oe_out  (miso_oe),
        .chip_reset_out   (chip_reset),
        .state_reset_out  (state_reset),
        .measuring_out    (measuring),
        .stop_open_out    (stop_open),
        .irq_n_out        (irq_n),
        .cfg_flat_out     (cfg_flat)
    );

    tcs_spi_host tcs_spi_host_i (
        .core_clk_in (core_clk),
        .miso_in     (miso_pin),
        .sck_out     (sck),
        .sel_n_out   (sel_n),
        .mosi_out    (mosi),
        .rx_byte_out (rx_byte),
        .rx_stb_out  (rx_stb)
    );

    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    function automatic logic [7:0] res_byte(input int a);
        int          c;
        int          k;
        logic [23:0] fld;
        logic [39:0] prod;
        if (a < 8)
            return 8'h00;
        c = (a - 8) / 6;
        k = (a - 8) % 6;
        if (chan_empty[c])
            return 8'hff;
        prod = chan_phase[c*PHASE_BITS+:PHASE_BITS] * {cfg_m[5][3:0], cfg_m[4], cfg_m[3]};
        fld = (k < 3) ? chan_index[c*FIELD_BITS+:FIELD_BITS] : {FINE_PAD, prod[35:16]};
        fld = fld >> (8 * (2 - k % 3));
        return fld[7:0];
    endfunction

    // results leave over SPI only; no serial output link is clocked
    task automatic rd(input logic [7:0] opc, input int n);
        logic [7:0] tx[$];
        int         a;
        tx = {opc};
        for (int j = 0; j < n; j++)
        begin
            a = (opc[4:0] + j) % 32;
            if (opc[7:5] == OPC_READ_CFG)
                exp_q.push_back((a < CFG_COUNT) ? cfg_m[a] : 8'h00);
            else
                exp_q.push_back(res_byte(a));
            tx.push_back(8'($urandom));
        end
        tcs_spi_host_i.frame(tx, 1);
    endtask

    task automatic cmd(input logic [7:0] opc);
        logic [7:0] tx[$];
        tx = {opc};
        tcs_spi_host_i.frame(tx, 99);
    endtask

    task automatic check_cfg();
        for (int i = 0; i < CFG_COUNT; i++)
            check(cfg_flat[i*8+:8], cfg_m[i]);
    endtask

    task automatic ref_pulses(input int n);
        repeat (n)
        begin
            ref_clk <= 1'b1;
            repeat (3) @(posedge core_clk);
            ref_clk <= 1'b0;
            repeat (3) @(posedge core_clk);
        end
    endtask

    always @(posedge core_clk)
    begin
        if (rx_stb === 1'b1)
        begin
            if (exp_q.size() > 0)
                check(rx_byte, exp_q.pop_front());
            else
                check(rx_byte, 24'hffffff);
        end
    end

    // state reset stands one cycle only, so count it where it stands
    always @(posedge core_clk)
        if (state_reset === 1'b1)
            init_pulses++;

    initial
    begin
        repeat (50000) @(posedge core_clk);
        error_cnt++;
        $display("unexpected at %0t: run hung", $time);
        give_verdict();
    end

    initial
    begin
        logic [7:0] tx[$];
        void'($urandom(32'h687cde50));
        arst_n     = 1'b0;
        ref_clk    = 1'b0;
        chan_empty = 4'hf;
        chan_index = '0;
        chan_phase = '0;
        foreach (cfg_m[i])
            cfg_m[i] = CFG_RESET_VAL;
        repeat (12) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (2) @(posedge core_clk);
        check_cfg();
        check(irq_n, 1'b1);
        // full load from register 0, last byte lands past the end
        tx.push_back({OPC_WRITE_CFG, 5'h00});
        foreach (cfg_m[i])
        begin
            // low nibble of reg 5 clear keeps the count below 2^16
            cfg_m[i] = (i == 5) ? 8'($urandom) & 8'hf0 : 8'($urandom);
            tx.push_back(cfg_m[i]);
        end
        tx.push_back(8'h5a);
        tcs_spi_host_i.frame(tx, 99);
        check_cfg();
        check(miso_oe, 1'b0);
        rd({OPC_READ_CFG, 5'h03}, 16);
        chan_empty <= 4'b1010;
        chan_index <= {$urandom, $urandom, $urandom};
        // full-scale phase on channel 0 gives the largest value
        chan_phase <= {16'($urandom), 16'($urandom), 16'($urandom), 16'hffff};
        repeat (3) @(posedge core_clk);
        check(irq_n, 1'b0);
        rd({OPC_READ_RES, 5'h07}, 14);
        // channel 2 stop bytes, empty channel 3, then wrap to 0
        rd({OPC_READ_RES, 5'h17}, 10);
        cmd(OPC_INIT);
        check(measuring, 1'b1);
        check(stop_open, 1'b0);
        check(24'(init_pulses), 24'h000001);
        ref_pulses(15); // one pulse short of the 16 that open the stops
        check(stop_open, 1'b0);
        ref_pulses(1);
        check(stop_open, 1'b1);
        check_cfg();
        rd({OPC_READ_RES, 5'h08}, 6);
        chan_empty <= 4'hf;
        cmd(OPC_POWER);
        check(chip_reset, 1'b1);
        check(measuring, 1'b0);
        check(stop_open, 1'b0);
        foreach (cfg_m[i])
            cfg_m[i] = CFG_RESET_VAL;
        check_cfg();
        check(irq_n, 1'b1);
        repeat (SELECT_HOLD_CYCLES + 5) @(posedge core_clk);
        check(chip_reset, 1'b0);
        rd({OPC_READ_CFG, 5'h10}, 3);
        check(24'(exp_q.size()), 24'h000000);
        give_verdict();
    end
endmodule

// [testbench/tcs_spi_host.sv]
/*
 * SPI host model: frames bytes on select, clock and data, reports read bytes.
 * Assumes the caller spaces frames and drives the core clock.
 */
`timescale 1ns/1ps
module tcs_spi_host
(
    input  wire logic       core_clk_in,
    input  wire logic       miso_in,
    output logic            sck_out,
    output logic            sel_n_out,
    output logic            mosi_out,
    output logic      [7:0] rx_byte_out,
    output logic            rx_stb_out
);
    initial
    begin
        sck_out     = 1'b0;
        sel_n_out   = 1'b1;
        mosi_out    = 1'b0;
        rx_byte_out = 8'h00;
        rx_stb_out  = 1'b0;
    end

    // bytes before index skip are opcode or write data, not reported
    task automatic frame(input logic [7:0] tx[$], input int skip);
        logic [7:0] rb;
        @(posedge core_clk_in);
        sel_n_out <= 1'b1;
        repeat (2) @(posedge core_clk_in);
        sel_n_out <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        foreach (tx[i])
        begin
            for (int b = 7; b >= 0; b--)
            begin
                sck_out  <= 1'b1;
                mosi_out <= tx[i][b];
                repeat (4) @(posedge core_clk_in);
                sck_out <= 1'b0;
                rb[b]   = miso_in;
                repeat (4) @(posedge core_clk_in);
            end
            rx_byte_out <= rb;
            rx_stb_out  <= (i >= skip);
            @(posedge core_clk_in);
            rx_stb_out <= 1'b0;
        end
        sel_n_out <= 1'b1;
        // released: inverted so a stale bit never looks like data
        mosi_out <= ~mosi_out;
        repeat (2) @(posedge core_clk_in);
    endtask
endmodule
